// *** verilog/pee_regs.vh ***
`ifndef PEE_REGS_VH
`define PEE_REGS_VH

`define PEE_CLK_PERIOD_PS      5000
`define PEE_WR_PULSE_NS        100
`define PEE_WR_PULSE_CYC       20
`define PEE_RD_ACCESS_NS       150
`define PEE_RD_ACCESS_CYC      30
`define PEE_FLOAT_NS           50
`define PEE_FLOAT_CYC          10
`define PEE_BLC_MIN_NS         100
`define PEE_BLC_MIN_CYC        20
`define PEE_BLC_MAX_US         100
`define PEE_BLC_MAX_CYC        20000
`define PEE_WC_MS              5
`define PEE_WC_CYC             1000000
`define PEE_INIT_MS            10
`define PEE_INIT_CYC           2000000
`define PEE_PAGE_BYTES         64
`define PEE_POLL_BIT           7
`define PEE_TOGGLE_BIT         6
`define PEE_CMD_ADDR_A         15'h5555
`define PEE_CMD_ADDR_B         15'h2AAA
`define PEE_CMD_D_AA           8'hAA
`define PEE_CMD_D_55           8'h55
`define PEE_CMD_D_A0           8'hA0
`define PEE_CMD_D_80           8'h80
`define PEE_CMD_D_20           8'h20
`define PEE_OP_READ            2'h0
`define PEE_OP_WRITE           2'h1
`define PEE_OP_LOCK            2'h2
`define PEE_OP_UNLOCK          2'h3

`endif

// *** verilog/pee_cmd_rom.v ***
`timescale 1ns/10ps
// ****************************************
// Protection command sequence table
// ****************************************
`include "pee_regs.vh"
module pee_cmd_rom (
    // Select
    input  wire        unlock_i,
    input  wire [2:0]  step_i,
    // Entry
    output reg  [14:0] addr_o,
    output reg  [7:0]  data_o,
    output reg  [2:0]  len_o
);
    always @* begin
        len_o  = unlock_i ? 3'h6 : 3'h3;
        addr_o = `PEE_CMD_ADDR_A;
        data_o = `PEE_CMD_D_AA;
        case (step_i)
            3'h1, 3'h4: begin
                addr_o = `PEE_CMD_ADDR_B;
                data_o = `PEE_CMD_D_55;
            end
            3'h2: begin
                data_o = unlock_i ? `PEE_CMD_D_80 : `PEE_CMD_D_A0;
            end
            3'h5: begin
                data_o = `PEE_CMD_D_20;
            end
            default: begin
                addr_o = `PEE_CMD_ADDR_A;
            end
        endcase
    end
endmodule

// *** verilog/pee_host.v ***
`timescale 1ns/10ps
`include "pee_regs.vh"
module pee_host #(
    parameter WC_CYC   = `PEE_WC_CYC,
    parameter INIT_CYC = `PEE_INIT_CYC,
    parameter BLC_CYC  = `PEE_BLC_MAX_CYC
) (
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        resetn_i,
    // User command
    input  wire        req_valid_i,
    input  wire [1:0]  req_op_i,
    input  wire [14:0] req_addr_i,
    input  wire [7:0]  req_wdata_i,
    input  wire        req_last_i,
    input  wire        lock_on_i,
    output reg         req_ready_o,
    output reg         rsp_valid_o,
    output reg  [7:0]  rsp_rdata_o,
    output reg         busy_o,
    // Memory pins
    output reg  [14:0] mem_addr_o,
    output reg         mem_cs_n_o,
    output reg         mem_we_n_o,
    output reg         mem_oe_n_o,
    output reg  [7:0]  mem_dq_o,
    output reg         mem_dq_oe_o,
    input  wire [7:0]  mem_dq_i
);
    // ****************************************
    // States
    // ****************************************
    localparam [7:0] S_INIT  = 8'h01;
    localparam [7:0] S_IDLE  = 8'h02;
    localparam [7:0] S_WLOW  = 8'h04;
    localparam [7:0] S_WHIGH = 8'h08;
    localparam [7:0] S_RD    = 8'h10;
    localparam [7:0] S_FLOAT = 8'h20;
    localparam [7:0] S_SEAL  = 8'h40;
    localparam [7:0] S_POLL  = 8'h80;

    reg  [7:0]  state_reg;
    reg  [21:0] cnt_reg;
    reg  [21:0] wc_reg;
    reg  [2:0]  step_reg;
    reg         cmd_reg;
    reg         unlock_reg;
    reg         rd_poll_reg;
    reg  [7:0]  last_data_reg;
    reg  [14:0] last_addr_reg;
    reg         pend_reg;
    reg  [14:0] pend_addr_reg;
    reg  [7:0]  pend_data_reg;
    reg         pend_last_reg;
    wire [14:0] rom_addr;
    wire [7:0]  rom_data;
    wire [2:0]  rom_len;

    pee_cmd_rom u_rom (
        .unlock_i (unlock_reg),
        .step_i   (step_reg),
        .addr_o   (rom_addr),
        .data_o   (rom_data),
        .len_o    (rom_len)
    );

    function poll_done;
        input [7:0] rd;
        input [7:0] wr;
        begin
            poll_done = (rd[`PEE_POLL_BIT] == wr[`PEE_POLL_BIT]);
        end
    endfunction

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg     <= S_INIT;
            cnt_reg       <= 22'h0;
            wc_reg        <= 22'h0;
            step_reg      <= 3'h0;
            cmd_reg       <= 1'b0;
            unlock_reg    <= 1'b0;
            rd_poll_reg   <= 1'b0;
            last_data_reg <= 8'h00;
            last_addr_reg <= 15'h0000;
            pend_reg      <= 1'b0;
            pend_addr_reg <= 15'h0000;
            pend_data_reg <= 8'h00;
            pend_last_reg <= 1'b0;
            req_ready_o   <= 1'b0;
            rsp_valid_o   <= 1'b0;
            rsp_rdata_o   <= 8'h00;
            busy_o        <= 1'b1;
            mem_addr_o    <= 15'h0000;
            mem_cs_n_o    <= 1'b1;
            mem_we_n_o    <= 1'b1;
            mem_oe_n_o    <= 1'b1;
            mem_dq_o      <= 8'h00;
            mem_dq_oe_o   <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            req_ready_o <= 1'b0;
            wc_reg      <= wc_reg + 22'h1;
            case (state_reg)
                S_INIT: begin
                    // Full lockout before any write
                    if (cnt_reg == INIT_CYC[21:0]) begin
                        cnt_reg     <= 22'h0;
                        busy_o      <= 1'b0;
                        req_ready_o <= 1'b1;
                        state_reg   <= S_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 22'h1;
                    end
                end
                S_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o   <= 1'b0;
                        busy_o        <= 1'b1;
                        cnt_reg       <= 22'h0;
                        step_reg      <= 3'h0;
                        pend_addr_reg <= req_addr_i;
                        pend_data_reg <= req_wdata_i;
                        pend_last_reg <= req_last_i;
                        unlock_reg    <= (req_op_i == `PEE_OP_UNLOCK);
                        if (req_op_i == `PEE_OP_READ) begin
                            // Read: write high, cs and oe low
                            rd_poll_reg <= 1'b0;
                            mem_addr_o  <= req_addr_i;
                            mem_cs_n_o  <= 1'b0;
                            mem_oe_n_o  <= 1'b0;
                            state_reg   <= S_RD;
                        end else begin
                            // Locked data preceded by arming
                            cmd_reg  <= (req_op_i != `PEE_OP_WRITE)
                                        || lock_on_i;
                            pend_reg <= (req_op_i == `PEE_OP_WRITE);
                            state_reg <= S_WLOW;
                        end
                    end
                end
                S_WLOW: begin
                    // Output drive high before strobes fall
                    mem_oe_n_o  <= 1'b1;
                    mem_cs_n_o  <= 1'b0;
                    mem_we_n_o  <= 1'b0;
                    mem_dq_oe_o <= 1'b1;
                    // Address steady at falling edge
                    mem_addr_o  <= cmd_reg ? rom_addr : pend_addr_reg;
                    mem_dq_o    <= cmd_reg ? rom_data : pend_data_reg;
                    // Pulse well over 20 ns
                    if (cnt_reg == `PEE_WR_PULSE_CYC) begin
                        cnt_reg    <= 22'h0;
                        // Both rise together, data held past
                        mem_we_n_o <= 1'b1;
                        mem_cs_n_o <= 1'b1;
                        state_reg  <= S_WHIGH;
                    end else begin
                        cnt_reg <= cnt_reg + 22'h1;
                    end
                end
                S_WHIGH: begin
                    mem_dq_oe_o <= 1'b0;
                    // Next load inside byte window
                    if (cnt_reg >= `PEE_BLC_MIN_CYC) begin
                        cnt_reg <= 22'h0;
                        if (cmd_reg && step_reg != rom_len - 3'h1) begin
                            step_reg  <= step_reg + 3'h1;
                            state_reg <= S_WLOW;
                        end else if (cmd_reg && pend_reg) begin
                            cmd_reg   <= 1'b0;
                            state_reg <= S_WLOW;
                        end else if (!cmd_reg && !pend_last_reg) begin
                            // Further page loads share the window
                            state_reg   <= S_SEAL;
                            req_ready_o <= 1'b1;
                        end else begin
                            last_addr_reg <= cmd_reg ? rom_addr
                                                     : pend_addr_reg;
                            last_data_reg <= cmd_reg ? rom_data
                                                     : pend_data_reg;
                            state_reg     <= S_SEAL;
                            pend_last_reg <= 1'b1;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 22'h1;
                    end
                end
                S_SEAL: begin
                    if (!pend_last_reg) begin
                        // Next page byte: must arrive in time
                        req_ready_o <= 1'b1;
                        if (req_valid_i && req_ready_o) begin
                            req_ready_o   <= 1'b0;
                            cnt_reg       <= 22'h0;
                            pend_addr_reg <= req_addr_i;
                            pend_data_reg <= req_wdata_i;
                            pend_last_reg <= req_last_i;
                            state_reg     <= S_WLOW;
                        end else if (cnt_reg == BLC_CYC[21:0]) begin
                            pend_last_reg <= 1'b1;
                            last_addr_reg <= pend_addr_reg;
                            last_data_reg <= pend_data_reg;
                            cnt_reg       <= 22'h0;
                        end else begin
                            cnt_reg <= cnt_reg + 22'h1;
                        end
                    end else if (cnt_reg == BLC_CYC[21:0]) begin
                        // Write held high a full window
                        cnt_reg     <= 22'h0;
                        wc_reg      <= 22'h0;
                        rd_poll_reg <= 1'b1;
                        state_reg   <= S_POLL;
                    end else begin
                        cnt_reg <= cnt_reg + 22'h1;
                    end
                end
                S_POLL: begin
                    // No writes until complete
                    // Bounded: refused or command-only writes poll true only if the stored bit 7 matches
                    if (wc_reg >= WC_CYC[21:0]) begin
                        rd_poll_reg <= 1'b0;
                        busy_o      <= 1'b0;
                        rsp_valid_o <= 1'b1;
                        state_reg   <= S_IDLE;
                    end else begin
                        mem_addr_o <= last_addr_reg;
                        mem_cs_n_o <= 1'b0;
                        mem_oe_n_o <= 1'b0;
                        cnt_reg    <= 22'h0;
                        state_reg  <= S_RD;
                    end
                end
                S_RD: begin
                    if (cnt_reg == `PEE_RD_ACCESS_CYC) begin
                        cnt_reg     <= 22'h0;
                        rsp_rdata_o <= mem_dq_i;
                        mem_oe_n_o  <= 1'b1;
                        mem_cs_n_o  <= 1'b1;
                        state_reg   <= S_FLOAT;
                    end else begin
                        cnt_reg <= cnt_reg + 22'h1;
                    end
                end
                S_FLOAT: begin
                    // Bus released before next drive
                    if (cnt_reg == `PEE_FLOAT_CYC) begin
                        cnt_reg <= 22'h0;
                        if (!rd_poll_reg) begin
                            busy_o      <= 1'b0;
                            rsp_valid_o <= 1'b1;
                            state_reg   <= S_IDLE;
                        end else if (poll_done(rsp_rdata_o,
                                               last_data_reg)) begin
                            // True data means done
                            rd_poll_reg <= 1'b0;
                            busy_o      <= 1'b0;
                            rsp_valid_o <= 1'b1;
                            state_reg   <= S_IDLE;
                        end else begin
                            state_reg <= S_POLL;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 22'h1;
                    end
                end
                default: begin
                    state_reg <= S_INIT;
                end
            endcase
        end
    end
endmodule

// *** verif/pee_host_monitor.sv ***
`timescale 1ns/10ps
// ****************
// Pin protocol checker
// ****************
module pee_host_monitor #(
    parameter INIT_CYC = 50
) (
    // Clock and reset
    input wire        sys_clk_i,
    input wire        resetn_i,
    // Status
    input wire        req_ready_o,
    input wire        busy_o,
    // Memory pins
    input wire [14:0] mem_addr_o,
    input wire        mem_cs_n_o,
    input wire        mem_we_n_o,
    input wire        mem_oe_n_o,
    input wire [7:0]  mem_dq_o,
    input wire        mem_dq_oe_o
);
    reg [21:0] up_reg;
    reg [7:0]  gap_reg;
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            up_reg  <= 22'h0;
            gap_reg <= 8'hFF;
        end else begin
            if (up_reg != 22'h3FFFFF)
                up_reg <= up_reg + 22'h1;
            if ($fell(mem_we_n_o))
                gap_reg <= 8'h00;
            else if (gap_reg != 8'hFF)
                gap_reg <= gap_reg + 8'h01;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    dq_free_a: assert property (mem_dq_oe_o |-> mem_oe_n_o)
        else $error("host drives data while output drive low");
    wr_mode_a: assert property (!mem_we_n_o |->
        mem_oe_n_o && !mem_cs_n_o && mem_dq_oe_o)
        else $error("write strobe low in a bad mode");
    rd_mode_a: assert property (!mem_oe_n_o |->
        mem_we_n_o && !mem_dq_oe_o)
        else $error("read overlaps a write");
    pulse_width_a: assert property ($fell(mem_we_n_o) |->
        !mem_we_n_o [*8])
        else $error("write pulse too short");
    addr_hold_a: assert property (!mem_we_n_o && !$past(mem_we_n_o) |->
        $stable(mem_addr_o) && $stable(mem_dq_o))
        else $error("address or data moved in write pulse");
    data_hold_a: assert property ($rose(mem_we_n_o) |->
        mem_dq_oe_o && $stable(mem_dq_o))
        else $error("data not held at strobe rise");
    load_gap_a: assert property ($fell(mem_we_n_o) |-> gap_reg >= 8'h13)
        else $error("byte loads closer than minimum");
    lockout_a: assert property (!mem_we_n_o |-> up_reg >= INIT_CYC)
        else $error("write during power-up lockout");
    ready_lock_a: assert property (up_reg < INIT_CYC - 2 |->
        busy_o && !req_ready_o)
        else $error("ready during lockout");
endmodule

bind pee_host pee_host_monitor #(.INIT_CYC(INIT_CYC)) pee_host_monitor_inst (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .req_ready_o (req_ready_o),
    .busy_o      (busy_o),
    .mem_addr_o  (mem_addr_o),
    .mem_cs_n_o  (mem_cs_n_o),
    .mem_we_n_o  (mem_we_n_o),
    .mem_oe_n_o  (mem_oe_n_o),
    .mem_dq_o    (mem_dq_o),
    .mem_dq_oe_o (mem_dq_oe_o)
);

// *** verif/pee_dev_model.sv ***
`timescale 1ns/10ps
// ****************
// Memory device model
// ****************
module pee_dev_model #(
    parameter BLC_CYC  = 40,
    parameter PROG_CYC = 300,
    parameter INIT_CYC = 40
) (
    input  wire        clk_i,
    input  wire        cs_n_i,
    input  wire        we_n_i,
    input  wire        oe_n_i,
    input  wire [14:0] addr_i,
    input  wire [7:0]  bus_i,
    output wire [7:0]  dq_o,
    output reg         lock_o
);
    reg [7:0]  mem [0:32767];
    reg [14:0] la [0:69];
    reg [7:0]  ld [0:69];
    reg [14:0] a_reg;
    reg [14:0] last_a;
    reg [7:0]  last_d;
    reg [7:0]  held;
    reg [7:0]  rv;
    reg        tog;
    reg        ok;
    integer    n, tmr, bsy, up, i, k;
    realtime   t_fall;
    wire act = !cs_n_i && !we_n_i && oe_n_i;
    wire rd  = !cs_n_i && !oe_n_i && we_n_i;
    initial begin
        for (i = 0; i < 32768; i = i + 1)
            mem[i] = 8'hFF;
        n = 0;
        tmr = 0;
        bsy = 0;
        up = 0;
        tog = 1'b0;
        lock_o = 1'b0;
        held = 8'h00;
        last_a = 15'h0000;
    end
    always @* begin
        if (bsy > 0 && addr_i == last_a)
            rv = {~last_d[7], tog, ~last_d[5:0]};
        else
            rv = mem[addr_i];
    end
    // Released bus shows the inverse, never a stale byte
    assign dq_o = rd ? rv : ~held;
    always @(negedge rd) held = rv;
    always @(negedge oe_n_i) tog = ~tog;
    always @(posedge act) begin
        a_reg = addr_i;
        t_fall = $realtime;
    end
    always @(negedge act) begin
        if ($realtime - t_fall >= 20.0 && bsy == 0 && up >= INIT_CYC) begin
            la[n] = a_reg;
            ld[n] = bus_i;
            n = n + 1;
            tmr = 0;
        end
    end
    task commit;
        begin
            k = 0;
            ok = !lock_o;
            if (n >= 3 && la[0] == 15'h5555 && ld[0] == 8'hAA &&
                la[1] == 15'h2AAA && ld[1] == 8'h55 && la[2] == 15'h5555) begin
                if (ld[2] == 8'hA0) begin
                    lock_o = 1'b1;
                    ok = 1'b1;
                    k = 3;
                end else if (n >= 6 && ld[2] == 8'h80 && ld[5] == 8'h20) begin
                    lock_o = 1'b0;
                    ok = 1'b1;
                    k = 6;
                end
            end
            for (i = k; i < n && ok; i = i + 1)
                mem[{la[n - 1][14:6], la[i][5:0]}] = ld[i];
            last_a = la[n - 1];
            last_d = ld[n - 1];
            if (ok)
                bsy = PROG_CYC;
            n = 0;
            tmr = 0;
        end
    endtask
    always @(posedge clk_i) begin
        if (up < INIT_CYC)
            up = up + 1;
        if (bsy > 0)
            bsy = bsy - 1;
        if (n > 0 && we_n_i)
            tmr = tmr + 1;
        if (tmr >= BLC_CYC)
            commit;
    end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb;
    reg         sys_clk_i   = 1'b0;
    reg         resetn_i    = 1'b0;
    reg         req_valid_i = 1'b0;
    reg  [1:0]  req_op_i    = 2'h0;
    reg  [14:0] req_addr_i  = 15'h0000;
    reg  [7:0]  req_wdata_i = 8'h00;
    reg         req_last_i  = 1'b1;
    reg         lock_on_i   = 1'b0;
    wire        ready, rsp_v, busy, cs_n, we_n, oe_n, hdq_oe, lock;
    wire [7:0]  rdata, hdq, ddq;
    wire [14:0] addr;
    wire [7:0]  bus = hdq_oe ? hdq : ddq;
    reg  [7:0]  got;
    integer     err_total = 0;
    integer     num_checks = 0;
    integer     cyc = 0;
    pee_host #(.WC_CYC(2000), .INIT_CYC(50), .BLC_CYC(40)) pee_host_inst (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .req_valid_i(req_valid_i), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_last_i(req_last_i), .lock_on_i(lock_on_i),
        .req_ready_o(ready), .rsp_valid_o(rsp_v), .rsp_rdata_o(rdata),
        .busy_o(busy), .mem_addr_o(addr), .mem_cs_n_o(cs_n),
        .mem_we_n_o(we_n), .mem_oe_n_o(oe_n), .mem_dq_o(hdq),
        .mem_dq_oe_o(hdq_oe), .mem_dq_i(bus));
    // Model default byte window (40) matches the host; its lockout (40) is shorter than the host's 50
    pee_dev_model
        pee_dev_model_inst (.clk_i(sys_clk_i), .cs_n_i(cs_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .addr_i(addr), .bus_i(bus), .dq_o(ddq), .lock_o(lock));
    always #2.5 sys_clk_i = ~sys_clk_i;
    task chk8(input [7:0] g, input [7:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task chk1(input g, input e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task step;
        begin
            @(posedge sys_clk_i);
            #1;
        end
    endtask
    task req(input [1:0] op, input [14:0] a, input [7:0] d, input last);
        begin
            req_valid_i = 1'b1;
            req_op_i = op;
            req_addr_i = a;
            req_wdata_i = d;
            req_last_i = last;
            while (ready !== 1'b1)
                step;
            step;
            req_valid_i = 1'b0;
            // Let an edge pass so a following request never re-raises valid
            step;
        end
    endtask
    task wait_rsp;
        begin
            step;
            while (rsp_v !== 1'b1)
                step;
            got = rdata;
        end
    endtask
    task rd(input [14:0] a);
        begin
            req(2'h0, a, 8'h00, 1'b1);
            wait_rsp;
        end
    endtask
    task t_lockout;
        integer w;
        begin
            w = 0;
            chk1(busy, 1'b1);
            chk1(ready, 1'b0);
            while (ready !== 1'b1) begin
                step;
                w = w + 1;
            end
            chk1(w >= 48, 1'b1);
            $display("test lockout done");
        end
    endtask
    task t_byte;
        begin
            req(2'h1, 15'h1234, 8'h5A, 1'b1);
            wait_rsp;
            chk8(pee_dev_model_inst.mem[15'h1234], 8'h5A);
            rd(15'h1234);
            chk8(got, 8'h5A);
            $display("test byte done");
        end
    endtask
    task t_page;
        begin
            pee_dev_model_inst.mem[15'h0042] = 8'h33;
            pee_dev_model_inst.mem[15'h1045] = 8'h77;
            req(2'h1, 15'h1045, 8'h01, 1'b0);
            req(2'h1, 15'h0041, 8'h02, 1'b0);
            req(2'h1, 15'h007F, 8'h03, 1'b1);
            wait_rsp;
            chk8(pee_dev_model_inst.mem[15'h0045], 8'h01);
            chk8(pee_dev_model_inst.mem[15'h1045], 8'h77);
            chk8(pee_dev_model_inst.mem[15'h0041], 8'h02);
            chk8(pee_dev_model_inst.mem[15'h007F], 8'h03);
            rd(15'h0042);
            chk8(got, 8'h33);
            $display("test page done");
        end
    endtask
    task t_lock;
        begin
            pee_dev_model_inst.mem[15'h0200] = 8'h44;
            req(2'h2, 15'h0000, 8'h00, 1'b1);
            wait_rsp;
            chk1(lock, 1'b1);
            req(2'h1, 15'h0200, 8'h99, 1'b1);
            wait_rsp;
            rd(15'h0200);
            chk8(got, 8'h44);
            lock_on_i = 1'b1;
            req(2'h1, 15'h0200, 8'h66, 1'b1);
            wait_rsp;
            rd(15'h0200);
            chk8(got, 8'h66);
            req(2'h3, 15'h0000, 8'h00, 1'b1);
            wait_rsp;
            chk1(lock, 1'b0);
            lock_on_i = 1'b0;
            req(2'h1, 15'h0201, 8'h12, 1'b1);
            wait_rsp;
            chk8(pee_dev_model_inst.mem[15'h0201], 8'h12);
            $display("test lock done");
        end
    endtask
    task summarize;
        begin
            $display("checks=%0d mismatches=%0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // Ceiling well above the longest expected run
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t timeout cycles=%h limit=%h", $time, cyc,
                     32'h00009C40);
            summarize;
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk_i);
        #1;
        resetn_i = 1'b1;
        t_lockout;
        t_byte;
        t_page;
        t_lock;
        summarize;
    end
endmodule
